// file: core/rsf_sequencer.sv
// Contract
// - each rail powers up its own delay after control turns on
// - control off powers rails down, each after its own turn-off delay
// - turn-on and turn-off delays clipped to 655 ms
// - rail delays timed from the one shared control edge, or from the end of a retry period
// - readings come from one multiplexed converter scanned in a timed loop
// - margin high/low/nominal; ignore-faults variant suppresses faults
// - fault shuts rails, pulses fault line, holds alert, retries later
// - alert held until clear-faults command or reset
// - rails come back automatically after the retry period if control is still on
// - reset restores initial state and reloads stored configuration
// - host writes go to working copy; store command makes them persist
// - with log-on-fault set, fault log saved automatically on a fault
// - saved log locked against overwrite until host clears it
// - restored log area frozen while live readings keep updating
// - log holds several loops newest first with loop count, uptime, readings
// - uptime counts from the latest reset
// - clear-and-rearm unlocks the saved log for the next fault
// - output short shows as undervoltage; prior entry stays nominal
// - shared fault line open drain, active low, also sensed as input
`timescale 1ns/10ps
module rsf_sequencer import rsf_pkg::*; #(
    parameter int LOOP_CYC = LOOP_CYC_DEF
) (
    // clock and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // control and shared lines
    input wire logic ctrl_in,
    input wire logic fault_in_n,
    output logic fault_o,
    output logic fault_oe_n,
    input wire logic alert_in,
    output logic alert_o,
    output logic alert_oe_n,
    // rails
    input wire logic [NCH-1:0] uv_in,
    output logic [NCH-1:0] rail_en,
    output logic margin_hi,
    output logic margin_lo,
    // converter
    output logic [2:0] adc_sel,
    output logic adc_start,
    input wire logic adc_done,
    input wire logic [15:0] adc_data
);
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [4:0] ctrl_r;
    logic [15:0] ton_r [NCH];
    logic [15:0] toff_r [NCH];
    logic [15:0] retry_r;
    logic [4:0] nvm_ctrl_r;
    logic [15:0] nvm_ton_r [NCH];
    logic [15:0] nvm_toff_r [NCH];
    logic [15:0] nvm_retry_r;
    logic load_r;
    logic [NCH-1:0] rail_en_r;
    logic fault_oe_n_r;
    logic alert_oe_n_r;
    logic margin_hi_r;
    logic margin_lo_r;
    logic ctrl_d_r;
    logic [8:0] pre_r;
    logic [5:0] pulse_r;
    rsf_state_t st_r;
    logic [15:0] retry_cnt_r;
    logic [31:0] uptime_r;
    logic [31:0] loops_r;
    logic [31:0] loop_cnt_r;
    logic [2:0] adc_sel_r;
    logic adc_start_r;
    logic busy_r;
    logic [15:0] samp_r [NSAMP];
    logic [31:0] ram_log_r [LOG_DEPTH][LOG_WORDS];
    logic [31:0] nvm_log_r [LOG_DEPTH][LOG_WORDS];
    logic locked_r;
    logic frozen_r;
    logic tick;
    logic ctrl_on;
    logic rise;
    logic fall;
    logic fault_evt;
    logic retry_done;
    logic seq_on;
    logic wr;
    logic hit;
    logic [31:0] rdata;
    logic [15:0] wdly;
    logic cmd_cf;
    logic cmd_store;
    logic cmd_rearm;
    logic cmd_restore;
    logic push;
    logic [1:0] ent;
    logic [2:0] wrd;

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign rail_en = rail_en_r;
    assign fault_o = 1'b0;
    assign fault_oe_n = fault_oe_n_r;
    assign alert_o = 1'b0;
    assign alert_oe_n = alert_oe_n_r;
    assign margin_hi = margin_hi_r;
    assign margin_lo = margin_lo_r;
    assign adc_sel = adc_sel_r;
    assign adc_start = adc_start_r;

    // apb decode
    assign wr = psel & penable & pready_r & pwrite & hit;
    assign ent = paddr[6:5];
    assign wrd = paddr[4:2];
    assign wdly = (pwdata > 32'(DLY_MAX)) ? DLY_MAX : pwdata[15:0];
    assign cmd_cf = wr & (paddr == CMD_OFF) & pwdata[CMD_CF];
    assign cmd_store = wr & (paddr == CMD_OFF) & pwdata[CMD_STORE];
    assign cmd_rearm = wr & (paddr == CMD_OFF) & pwdata[CMD_REARM];
    assign cmd_restore = wr & (paddr == CMD_OFF) & pwdata[CMD_RESTORE];

    always_comb begin
        rdata = 32'h0000_0000;
        hit = 1'b1;
        if (paddr == CTRL_OFF) begin
            rdata = {27'h0, ctrl_r};
        end else if (paddr == CMD_OFF) begin
            rdata = 32'h0000_0000;
        end else if (paddr == STAT_OFF) begin
            rdata = {23'h0, ctrl_on, st_r == ST_RETRY, frozen_r, locked_r,
                     ~alert_oe_n_r, rail_en_r};
        end else if (paddr == RETRY_OFF) begin
            rdata = {16'h0, retry_r};
        end else if (paddr == UPTIME_OFF) begin
            rdata = uptime_r;
        end else if (paddr[11:4] == TON_OFF[11:4] && paddr[1:0] == 2'h0) begin
            rdata = {16'h0, ton_r[paddr[3:2]]};
        end else if (paddr[11:4] == TOFF_OFF[11:4] && paddr[1:0] == 2'h0) begin
            rdata = {16'h0, toff_r[paddr[3:2]]};
        end else if (paddr[11:5] == LIVE_OFF[11:5] && wrd < 3'(NSAMP)
                     && paddr[1:0] == 2'h0) begin
            rdata = {16'h0, samp_r[wrd]};
        end else if (paddr[11:7] == RAMLOG_OFF[11:7] && paddr[1:0] == 2'h0) begin
            rdata = ram_log_r[ent][wrd];
        end else if (paddr[11:7] == NVMLOG_OFF[11:7] && paddr[1:0] == 2'h0) begin
            rdata = nvm_log_r[ent][wrd];
        end else begin
            hit = 1'b0;
        end
    end

    // no wait state: data sampled in setup, ready in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= psel & ~penable;
            if (psel & ~penable) begin
                prdata_r <= pwrite ? 32'h0000_0000 : rdata;
                pslverr_r <= ~hit;
            end
        end
    end

    // working configuration, reloaded from storage after every reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_r <= 1'b1;
            ctrl_r <= CTRL_RST;
            retry_r <= RETRY_RST;
            ton_r <= '{default: TON_RST};
            toff_r <= '{default: TOFF_RST};
        end else if (load_r) begin
            load_r <= 1'b0;
            ctrl_r <= nvm_ctrl_r;
            retry_r <= nvm_retry_r;
            ton_r <= nvm_ton_r;
            toff_r <= nvm_toff_r;
        end else if (wr) begin
            if (paddr == CTRL_OFF) begin
                ctrl_r <= pwdata[4:0];
            end
            if (paddr == RETRY_OFF) begin
                retry_r <= pwdata[15:0];
            end
            if (paddr[11:4] == TON_OFF[11:4]) begin
                ton_r[paddr[3:2]] <= wdly;
            end
            if (paddr[11:4] == TOFF_OFF[11:4]) begin
                toff_r[paddr[3:2]] <= wdly;
            end
        end
    end

    // stored copy survives presetn; only power-on clears it
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            nvm_ctrl_r <= CTRL_RST;
            nvm_retry_r <= RETRY_RST;
            nvm_ton_r <= '{default: TON_RST};
            nvm_toff_r <= '{default: TOFF_RST};
        end else if (cmd_store) begin
            nvm_ctrl_r <= ctrl_r;
            nvm_retry_r <= retry_r;
            nvm_ton_r <= ton_r;
            nvm_toff_r <= toff_r;
        end
    end

    // shared time base and control edges
    assign tick = (pre_r == 9'(TICK_CYC - 1));
    assign ctrl_on = ctrl_in & ctrl_r[CTRL_RUN] & ~load_r;
    assign rise = ctrl_on & ~ctrl_d_r;
    assign fall = ~ctrl_on & ctrl_d_r;
    assign fault_evt = (st_r == ST_RUN) & ~ctrl_r[CTRL_IGN]
        & ((|(uv_in & rail_en_r)) | (~fault_in_n & fault_oe_n_r));
    assign retry_done = (st_r == ST_RETRY) & tick & (retry_cnt_r == 16'h0000);
    assign seq_on = (rise & (st_r == ST_RUN)) | (retry_done & ctrl_on);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r <= 9'h000;
            ctrl_d_r <= 1'b0;
            uptime_r <= 32'h0000_0000;
        end else begin
            // restart on control edges: delays count whole ticks; uptime may slip a part tick
            pre_r <= (tick | rise | fall) ? 9'h000 : pre_r + 9'h001;
            ctrl_d_r <= ctrl_on;
            if (tick) begin
                uptime_r <= uptime_r + 32'h0000_0001;
            end
        end
    end

    // fault and retry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_RUN;
            retry_cnt_r <= 16'h0000;
        end else begin
            unique case (st_r)
                ST_RUN: begin
                    if (fault_evt) begin
                        st_r <= ST_RETRY;
                        retry_cnt_r <= retry_r;
                    end
                end
                ST_RETRY: begin
                    if (retry_done) begin
                        st_r <= ST_RUN;
                    end else if (tick) begin
                        retry_cnt_r <= retry_cnt_r - 16'h0001;
                    end
                end
            endcase
        end
    end

    // fault line pulse and latched alert
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_r <= 6'h00;
            fault_oe_n_r <= 1'b1;
            alert_oe_n_r <= 1'b1;
        end else begin
            if (fault_evt) begin
                pulse_r <= PULSE_CYC - 6'h01;
                fault_oe_n_r <= 1'b0;
            end else if (pulse_r != 6'h00) begin
                pulse_r <= pulse_r - 6'h01;
            end else begin
                fault_oe_n_r <= 1'b1;
            end
            if (fault_evt) begin
                alert_oe_n_r <= 1'b0;
            end else if (cmd_cf) begin
                alert_oe_n_r <= 1'b1;
            end
        end
    end

    // margin outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            margin_hi_r <= 1'b0;
            margin_lo_r <= 1'b0;
        end else begin
            margin_hi_r <= ctrl_r[CTRL_MHI] & ~ctrl_r[CTRL_MLO];
            margin_lo_r <= ctrl_r[CTRL_MLO] & ~ctrl_r[CTRL_MHI];
        end
    end

    // per-rail sequencer
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic [15:0] on_cnt_r;
        logic [15:0] off_cnt_r;
        logic on_pend_r;
        logic off_pend_r;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                on_cnt_r <= 16'h0000;
                off_cnt_r <= 16'h0000;
                on_pend_r <= 1'b0;
                off_pend_r <= 1'b0;
                rail_en_r[i] <= 1'b0;
            end else if (fault_evt) begin
                rail_en_r[i] <= 1'b0;
                on_pend_r <= 1'b0;
                off_pend_r <= 1'b0;
            end else if (seq_on) begin
                on_pend_r <= 1'b1;
                off_pend_r <= 1'b0;
                on_cnt_r <= ton_r[i];
            end else if (fall) begin
                off_pend_r <= 1'b1;
                on_pend_r <= 1'b0;
                off_cnt_r <= toff_r[i];
            end else begin
                if (on_pend_r) begin
                    if (on_cnt_r == 16'h0000) begin
                        rail_en_r[i] <= 1'b1;
                        on_pend_r <= 1'b0;
                    end else if (tick) begin
                        on_cnt_r <= on_cnt_r - 16'h0001;
                    end
                end
                if (off_pend_r) begin
                    if (off_cnt_r == 16'h0000) begin
                        rail_en_r[i] <= 1'b0;
                        off_pend_r <= 1'b0;
                    end else if (tick) begin
                        off_cnt_r <= off_cnt_r - 16'h0001;
                    end
                end
            end
        end
    end

    // converter scan loop
    assign push = busy_r & adc_done & (adc_sel_r == 3'(NSAMP - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_cnt_r <= 32'h0000_0000;
            loops_r <= 32'h0000_0000;
            adc_sel_r <= 3'h0;
            adc_start_r <= 1'b0;
            busy_r <= 1'b0;
            samp_r <= '{default: 16'h0000};
        end else begin
            adc_start_r <= 1'b0;
            if (loop_cnt_r == 32'(LOOP_CYC - 1)) begin
                loop_cnt_r <= 32'h0000_0000;
                if (!busy_r) begin
                    busy_r <= 1'b1;
                    adc_sel_r <= 3'h0;
                    adc_start_r <= 1'b1;
                end
            end else begin
                loop_cnt_r <= loop_cnt_r + 32'h0000_0001;
            end
            if (busy_r & adc_done) begin
                samp_r[adc_sel_r] <= adc_data;
                if (push) begin
                    busy_r <= 1'b0;
                    loops_r <= loops_r + 32'h0000_0001;
                end else begin
                    adc_sel_r <= adc_sel_r + 3'h1;
                    adc_start_r <= 1'b1;
                end
            end
        end
    end

    // working log: newest loop in entry 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_log_r <= '{default: '{default: 32'h0000_0000}};
        end else if (cmd_restore) begin
            ram_log_r <= nvm_log_r;
        end else if (push & ~frozen_r) begin
            for (int e = LOG_DEPTH - 1; e > 0; e--) begin
                ram_log_r[e] <= ram_log_r[e - 1];
            end
            ram_log_r[0][0] <= loops_r;
            ram_log_r[0][1] <= uptime_r;
            for (int s = 0; s < NSAMP - 1; s++) begin
                ram_log_r[0][s + 2] <= {16'h0, samp_r[s]};
            end
            ram_log_r[0][NSAMP + 1] <= {16'h0, adc_data};
        end
    end

    // frozen cleared by rearm; a new restore in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frozen_r <= 1'b0;
        end else if (cmd_restore) begin
            frozen_r <= 1'b1;
        end else if (cmd_rearm) begin
            frozen_r <= 1'b0;
        end
    end

    // stored log and its lock live in the non-volatile domain
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            nvm_log_r <= '{default: '{default: 32'h0000_0000}};
            locked_r <= 1'b0;
        end else if (fault_evt & ctrl_r[CTRL_LOG] & ~locked_r) begin
            nvm_log_r <= ram_log_r;
            locked_r <= 1'b1;
        end else if (cmd_rearm) begin
            locked_r <= 1'b0;
        end
    end
endmodule // rsf_sequencer

// file: include/rsf_pkg.sv
package rsf_pkg;
    localparam int CLK_NS = 25;
    localparam int TICK_NS = 10000;
    localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int DLY_MAX_MS = 655;
    localparam logic [15:0] DLY_MAX = 16'(DLY_MAX_MS * 1000 / (TICK_NS / 1000));
    localparam int LOOP_MS = 100;
    localparam int LOOP_CYC_DEF = LOOP_MS * 1000000 / CLK_NS;
    localparam int PULSE_NS = 1000;
    localparam logic [5:0] PULSE_CYC = 6'((PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam int NCH = 4;
    localparam int NSAMP = 6;
    localparam int LOG_DEPTH = 4;
    localparam int LOG_WORDS = 8;
    // register offsets
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] CMD_OFF = 12'h004;
    localparam logic [11:0] STAT_OFF = 12'h008;
    localparam logic [11:0] RETRY_OFF = 12'h00c;
    localparam logic [11:0] UPTIME_OFF = 12'h010;
    localparam logic [11:0] TON_OFF = 12'h020;
    localparam logic [11:0] TOFF_OFF = 12'h030;
    localparam logic [11:0] LIVE_OFF = 12'h040;
    localparam logic [11:0] RAMLOG_OFF = 12'h100;
    localparam logic [11:0] NVMLOG_OFF = 12'h200;
    // control fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_LOG = 1;
    localparam int CTRL_MHI = 2;
    localparam int CTRL_MLO = 3;
    localparam int CTRL_IGN = 4;
    localparam logic [4:0] CTRL_RST = 5'h03;
    // command fields
    localparam int CMD_CF = 0;
    localparam int CMD_STORE = 1;
    localparam int CMD_REARM = 2;
    localparam int CMD_RESTORE = 3;
    // reset values
    localparam logic [15:0] TON_RST = 16'h0000;
    localparam logic [15:0] TOFF_RST = 16'h0000;
    localparam logic [15:0] RETRY_RST = 16'h4e20;
    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_RETRY = 1'b1
    } rsf_state_t;
endpackage

// file: verif/rsf_asserts.sv
`timescale 1ns/10ps
module rsf_asserts import rsf_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // lines and rails
    input wire logic ctrl_in,
    input wire logic fault_in_n,
    input wire logic fault_o,
    input wire logic fault_oe_n,
    input wire logic alert_o,
    input wire logic alert_oe_n,
    input wire logic [NCH-1:0] uv_in,
    input wire logic [NCH-1:0] rail_en,
    // converter
    input wire logic [2:0] adc_sel,
    input wire logic adc_start,
    input wire logic adc_done
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] low_r;
    logic cf_wr;
    logic hit;
    assign cf_wr = psel && penable && pready && pwrite && paddr == CMD_OFF && pwdata[CMD_CF];
    assign hit = |(uv_in & rail_en);
    // length of the fault pulse so far
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            low_r <= 8'h00;
        else if (!fault_oe_n)
            low_r <= low_r + 8'h01;
        else
            low_r <= 8'h00;
    end
    fault_rails_a: assert property ($fell(fault_oe_n) |-> rail_en == '0)
        else $error("rails still on at fault");
    fault_cause_a: assert property ($fell(fault_oe_n) |-> $past(hit || !fault_in_n))
        else $error("fault without a cause");
    fault_alert_a: assert property ($fell(fault_oe_n) |-> !alert_oe_n)
        else $error("alert not raised with fault");
    pulse_len_a: assert property ($rose(fault_oe_n) |-> low_r == 8'(PULSE_CYC))
        else $error("fault pulse length wrong");
    alert_hold_a: assert property ($rose(alert_oe_n) |-> $past(cf_wr) || $past(cf_wr, 2))
        else $error("alert dropped without clear");
    fault_pins_a: assert property (fault_o == 1'b0 && alert_o == 1'b0)
        else $error("open drain line driven high");
    apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
    adc_next_a: assert property (adc_done && adc_sel < 3'd5 |=>
        adc_start && adc_sel == $past(adc_sel) + 3'd1)
        else $error("scan loop step wrong");
    rail_ctrl_a: assert property ((rail_en & ~$past(rail_en)) != '0 |->
        $past(ctrl_in) || $past(ctrl_in, 2))
        else $error("rail rose without control");
    cover property ($fell(fault_oe_n));
    cover property ($rose(alert_oe_n));
    cover property ($rose(&rail_en));
endmodule // rsf_asserts

bind rsf_sequencer rsf_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .ctrl_in(ctrl_in), .fault_in_n(fault_in_n), .fault_o(fault_o), .fault_oe_n(fault_oe_n),
    .alert_o(alert_o), .alert_oe_n(alert_oe_n), .uv_in(uv_in), .rail_en(rail_en),
    .adc_sel(adc_sel), .adc_start(adc_start), .adc_done(adc_done));

// file: verif/rsf_adc_model.sv
`timescale 1ns/10ps
module rsf_adc_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request
    input wire logic slow,
    input wire logic [2:0] adc_sel,
    input wire logic adc_start,
    // result
    output logic adc_done,
    output logic [15:0] adc_data
);
    logic [3:0] wait_r;
    logic [2:0] sel_r;
    // one conversion at a time, prompt or slow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r <= 4'h0;
            sel_r <= 3'h0;
            adc_done <= 1'b0;
            adc_data <= 16'h0000;
        end else begin
            adc_done <= wait_r == 4'h1;
            // data only valid with done; scrambled otherwise
            adc_data <= (wait_r == 4'h1) ? 16'h0a00 + 16'(sel_r) : ~adc_data;
            if (adc_start) begin
                wait_r <= slow ? 4'h7 : 4'h1;
                sel_r <= adc_sel;
            end else if (wait_r != 4'h0)
                wait_r <= wait_r - 4'h1;
        end
    end
endmodule // rsf_adc_model

// file: verif/rail_sequencer_fault_logger_test.sv
`timescale 1ns/10ps
module rail_sequencer_fault_logger_test import rsf_pkg::*;;
    logic pclk;
    logic presetn = 1'b0;
    logic por_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic ctrl_in = 1'b0;
    logic slow = 1'b0;
    logic [NCH-1:0] uv_in = '0;
    logic [31:0] prdata;
    logic pready, pslverr, fault_o, fault_oe_n, alert_o, alert_oe_n, fault_in_n, alert_in;
    logic [NCH-1:0] rail_en;
    logic margin_hi, margin_lo, adc_start, adc_done;
    logic [2:0] adc_sel;
    logic [15:0] adc_data;
    logic [NCH-1:0] rail_q = '0;
    logic ext_flt = 1'b0;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    int ton_t[NCH];
    int toff_t[NCH];
    // pulled-up open drain lines; ext_flt stands for another device
    assign fault_in_n = (fault_oe_n ? 1'b1 : fault_o) & ~ext_flt;
    assign alert_in = alert_oe_n ? 1'b1 : alert_o;
    rsf_sequencer #(.LOOP_CYC(200)) DUT (.pclk(pclk), .presetn(presetn), .por_n(por_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctrl_in(ctrl_in),
        .fault_in_n(fault_in_n), .fault_o(fault_o), .fault_oe_n(fault_oe_n),
        .alert_in(alert_in), .alert_o(alert_o), .alert_oe_n(alert_oe_n), .uv_in(uv_in),
        .rail_en(rail_en), .margin_hi(margin_hi), .margin_lo(margin_lo), .adc_sel(adc_sel),
        .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data));
    rsf_adc_model u_adc (.pclk(pclk), .presetn(presetn), .slow(slow), .adc_sel(adc_sel),
        .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        rail_q <= rail_en;
        for (int i = 0; i < NCH; i++) begin
            if (rail_en[i] && !rail_q[i]) ton_t[i] <= cyc;
            if (!rail_en[i] && rail_q[i]) toff_t[i] <= cyc;
        end
        if (cyc == 60000) begin
            err_total++;
            $display("timeout");
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask
    task automatic wait_rails(input logic [NCH-1:0] v);
        int n;
        n = 0;
        while (rail_en !== v && n < 8000) begin
            @(posedge pclk);
            n++;
        end
        @(posedge pclk);
    endtask
    // rail i: on delay 3-i ticks, off delay i ticks
    task automatic run_seq(input logic on);
        int t0;
        int t;
        int d;
        ctrl_in <= on;
        t0 = cyc;
        wait_rails(on ? 4'hf : 4'h0);
        for (int i = 0; i < NCH; i++) begin
            d = on ? 3 - i : i;
            t = (on ? ton_t[i] : toff_t[i]) - t0;
            chk("seq_dly", 1, 32'(t >= d * TICK_CYC && t <= (d + 1) * TICK_CYC + 8));
        end
    endtask
    task automatic pulse_reset;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    initial begin
        logic [31:0] q;
        logic [31:0] up;
        logic e;
        int t0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        rd(CTRL_OFF, q);
        chk("ctrl", {27'h0, CTRL_RST}, q);
        rd(RETRY_OFF, q);
        chk("retry", {16'h0, RETRY_RST}, q);
        apb(1'b0, 12'h0fc, 32'h0, q, e);
        chk("slverr", 1, e);
        wr(TON_OFF, 32'hffff);
        rd(TON_OFF, q);
        chk("ton_clip", {16'h0, DLY_MAX}, q);
        wr(TOFF_OFF + 12'h004, 32'h10000);
        rd(TOFF_OFF + 12'h004, q);
        chk("toff_clip", {16'h0, DLY_MAX}, q);
        $display("test registers done");
        for (int i = 0; i < NCH; i++) begin
            wr(TON_OFF + 12'(4 * i), 32'(3 - i));
            wr(TOFF_OFF + 12'(4 * i), 32'(i));
        end
        run_seq(1'b1);
        run_seq(1'b0);
        // reversal before rail 0 is due
        ctrl_in <= 1'b1;
        repeat (2 * TICK_CYC) @(posedge pclk);
        ctrl_in <= 1'b0;
        t0 = ton_t[0];
        repeat (5 * TICK_CYC) @(posedge pclk);
        chk("cancel", t0, ton_t[0]);
        chk("rails_idle", 0, rail_en);
        $display("test sequencing done");
        for (int m = 0; m < 3; m++) begin
            wr(CTRL_OFF, 32'h03 | (32'h4 << m));
            repeat (2) @(posedge pclk);
            chk("margin", 32'(2'b10 >> m), {margin_hi, margin_lo});
        end
        wr(CTRL_OFF, 32'h03);
        wr(RETRY_OFF, 32'h5);
        slow <= 1'b1;
        run_seq(1'b1);
        uv_in <= 4'h8;
        t0 = 0;
        while (fault_oe_n !== 1'b0 && t0 < 100) begin
            @(posedge pclk);
            t0++;
        end
        uv_in <= 4'h0;
        chk("rails_off", 0, rail_en);
        chk("alert", 0, alert_oe_n);
        rd(STAT_OFF, q);
        chk("locked", 1, q[5]);
        for (int j = 2; j < LOG_WORDS; j++) begin
            rd(NVMLOG_OFF + 12'(4 * j), q);
            chk("log_word", 32'h0a00 + 32'(j - 2), q);
        end
        wait_rails(4'hf);
        chk("retried", 4'hf, rail_en);
        chk("alert_hold", 0, alert_oe_n);
        wr(CTRL_OFF, 32'h13);
        uv_in <= 4'h8;
        repeat (10) @(posedge pclk);
        chk("ignored", 32'h1f, {fault_oe_n, rail_en});
        uv_in <= 4'h0;
        wr(CTRL_OFF, 32'h03);
        wr(CMD_OFF, 32'h1);
        repeat (3) @(posedge pclk);
        chk("alert_clr", 1, alert_oe_n);
        rd(LIVE_OFF + 12'h010, q);
        chk("live_vin", 32'h0a04, q);
        ext_flt <= 1'b1;
        @(posedge pclk);
        ext_flt <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("ext_fault", 32'h0, {fault_oe_n, rail_en});
        $display("test fault done");
        rd(UPTIME_OFF, up);
        wr(RETRY_OFF, 32'h7);
        ctrl_in <= 1'b0;
        pulse_reset();
        rd(RETRY_OFF, q);
        chk("no_store", {16'h0, RETRY_RST}, q);
        rd(UPTIME_OFF, q);
        chk("uptime", 1, 32'(q < up));
        rd(STAT_OFF, q);
        chk("lock_kept", 1, q[5]);
        wr(RETRY_OFF, 32'h9);
        wr(CMD_OFF, 32'h2);
        repeat (3) @(posedge pclk);
        pulse_reset();
        rd(RETRY_OFF, q);
        chk("stored", 32'h9, q);
        wr(CMD_OFF, 32'h8);
        rd(STAT_OFF, q);
        chk("frozen", 1, q[6]);
        wr(CMD_OFF, 32'h4);
        rd(STAT_OFF, q);
        chk("rearmed", 0, q[6:5]);
        $display("test store done");
        end_of_test();
    end
endmodule // rail_sequencer_fault_logger_test
